// ### src/fgas_regs.svh
`ifndef FGAS_REGS_SVH
`define FGAS_REGS_SVH

// register offsets on the internal register port
`define FGAS_OFS_STATUS 8'h00
`define FGAS_OFS_TEMP_LIM 8'hb2
`define FGAS_OFS_CFG 8'hdb

// event status bit positions
`define FGAS_ST_BR 15
`define FGAS_ST_SMX 14
`define FGAS_ST_TMX 13
`define FGAS_ST_VMX 12
`define FGAS_ST_BI 11
`define FGAS_ST_SMN 10
`define FGAS_ST_TMN 9
`define FGAS_ST_VMN 8
`define FGAS_ST_BST 3
`define FGAS_ST_POR 1

// smart charge configuration bit positions
`define FGAS_CFG_TMD 5
`define FGAS_CFG_SRC 4
`define FGAS_CFG_SCE 1
`define FGAS_CFG_SFE 0

// threshold field positions
`define FGAS_HI_MSB 15
`define FGAS_HI_LSB 8
`define FGAS_LO_MSB 7
`define FGAS_LO_LSB 0

// reset values and masks
`define FGAS_STATUS_RST 16'h0002
`define FGAS_TEMP_LIM_RST 16'h7f80
`define FGAS_CFG_RST 16'h0000
`define FGAS_CFG_MASK 16'h0033

// disable codes
`define FGAS_WARM_DIS 8'h7f
`define FGAS_COOL_DIS 8'h80
`define FGAS_MAX_DIS 8'hff
`define FGAS_MIN_DIS 8'h00

`endif

// ### src/fgas_pkg.sv
package fgas_pkg;
    typedef logic [7:0] fgas_byte_t;
    typedef logic [15:0] fgas_word_t;
    typedef enum logic {
        fgas_soc_mixed,
        fgas_soc_voltage
    } fgas_soc_src_e;
endpackage

// ### src/fgas_aux_if.sv
`timescale 1ns/1ps
interface fgas_aux_if;
    logic present;
    logic insert_pulse;
    logic remove_pulse;
    modport src (output present, output insert_pulse, output remove_pulse);
    modport dst (input present, input insert_pulse, input remove_pulse);
endinterface

// ### src/fgas_aux_detect.sv
`timescale 1ns/1ps
module fgas_aux_detect
    import fgas_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // pin, high while no battery sits in the holder
    input wire logic aux_sense_input,
    // detected events
    fgas_aux_if.src aux
);
    logic sync1;
    logic sync2;
    logic sync3;
    logic level;
    logic change;

    // a change counts only once the second and third stages agree
    assign change = (sync2 == sync3) && (sync3 != level);

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            sync1 <= 1'b0;
            sync2 <= 1'b0;
            sync3 <= 1'b0;
        end else begin
            sync1 <= aux_sense_input;
            sync2 <= sync1;
            sync3 <= sync2;
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            level <= 1'b0;
            aux.present <= 1'b1;
            aux.insert_pulse <= 1'b0;
            aux.remove_pulse <= 1'b0;
        end else begin
            if (change) begin
                level <= sync3;
            end
            aux.present <= change ? !sync3 : !level;
            aux.insert_pulse <= change && !sync3;
            aux.remove_pulse <= change && sync3;
        end
    end
endmodule

// ### src/fgas_alert_status.sv
`timescale 1ns/1ps
`include "fgas_regs.svh"

//Contract
// [R01] warm threshold bits 15:8, 1 C steps, T4 point, 0x7f disables
// [R02] cool threshold bits 7:0, 1 C steps, T1 point, 0x80 disables
// [R03] config bit 5 set stops temperature monitor adjustments
// [R04] config bit 4 picks mixed (0) or voltage (1) soc estimate
// [R05] config bit 1 enables the smart charge function
// [R06] config bit 0 enables the smart full detection function
// [R07] status bit 15 latches battery removal, cleared by software
// [R08] status bit 14 set when soc rises above max soc alert
// [R09] status bit 13 set when temperature exceeds max temp alert
// [R10] status bit 12 set when cell voltage exceeds max volt alert
// [R11] status bit 11 latches battery insertion from aux pin
// [R12] sticky selects decide whether alert bits need software clearing
// [R13] status register at offset 0x00 gathers latched event flags
// [R14] bits 10, 9, 8 set when soc, temp, voltage fall below minimum
// [R15] bit 1 set on any power-on reset, reads 1 after power-up
// [R16] bit 3 shows battery absence, 0 while present
// [R17] non-sticky alert bit clears itself once value returns inside
// [R18] writing 0 clears a status bit, 1 keeps it, events win
// [R19] a threshold at its disable code never raises an alert
module fgas_alert_status
    import fgas_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // register port behind the serial control interface
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_wdata,
    output logic [15:0] reg_rdata,
    output logic reg_ack,
    // gauge readings, same clock
    input wire logic [7:0] mixed_soc_estimate,
    input wire logic [7:0] voltage_soc_estimate,
    input wire logic [7:0] temperature_reading,
    input wire logic [7:0] cell_voltage_reading,
    // alert thresholds and sticky selects from neighbouring registers
    input wire logic [15:0] soc_alert_threshold,
    input wire logic [15:0] temp_alert_threshold,
    input wire logic [15:0] volt_alert_threshold,
    input wire logic soc_sticky_select,
    input wire logic temp_sticky_select,
    input wire logic volt_sticky_select,
    input wire logic [1:0] soc_alert_source_cfg,
    input wire logic sw_por_req,
    // pin
    input wire logic aux_sense_input,
    // smart charging controls
    output logic monitor_adjust_en,
    output logic smart_charge_function,
    output logic smart_full_function,
    output logic [7:0] smart_soc,
    output logic warm_zone,
    output logic cool_zone
);
    fgas_word_t status;
    fgas_word_t temp_limits;
    fgas_word_t smart_cfg;
    fgas_word_t next_status;
    fgas_aux_if aux ();
    logic st_wr;
    logic [15:0] clr;
    fgas_byte_t alert_soc;
    logic smx_c, tmx_c, vmx_c, smn_c, tmn_c, vmn_c;

    function automatic logic gt_s(input fgas_byte_t a, input fgas_byte_t b);
        return $signed(a) > $signed(b);
    endfunction

    function automatic logic keep_next(input logic cur, input logic set,
                                       input logic wipe);
        // a new event outweighs a clear in the same cycle
        return set | (cur & ~wipe);
    endfunction

    function automatic logic alert_next(input logic cur, input logic cond,
                                        input logic sticky,
                                        input logic wipe);
        return sticky ? keep_next(cur, cond, wipe) : cond;
    endfunction

    fgas_aux_detect u_aux (
        .ref_clk(ref_clk),
        .reset(reset),
        .aux_sense_input(aux_sense_input),
        .aux(aux.src)
    );

    assign st_wr = reg_wr && (reg_addr == `FGAS_OFS_STATUS); // [R13]
    assign clr = st_wr ? ~reg_wdata : 16'h0000; // [R18]
    // source field 1 compares the voltage based estimate, others the mix
    assign alert_soc = (soc_alert_source_cfg == 2'h1) ?
        voltage_soc_estimate : mixed_soc_estimate; // [R08] [R14]

    // disable codes sit at the end of range, checked anyway [R19]
    assign smx_c = (soc_alert_threshold[15:8] != `FGAS_MAX_DIS) &&
        (alert_soc > soc_alert_threshold[15:8]); // [R08]
    assign tmx_c = (temp_alert_threshold[15:8] != `FGAS_WARM_DIS) &&
        gt_s(temperature_reading, temp_alert_threshold[15:8]); // [R09]
    assign vmx_c = (volt_alert_threshold[15:8] != `FGAS_MAX_DIS) &&
        (cell_voltage_reading > volt_alert_threshold[15:8]); // [R10]
    assign smn_c = (soc_alert_threshold[7:0] != `FGAS_MIN_DIS) &&
        (alert_soc < soc_alert_threshold[7:0]); // [R14]
    assign tmn_c = (temp_alert_threshold[7:0] != `FGAS_COOL_DIS) &&
        gt_s(temp_alert_threshold[7:0], temperature_reading); // [R14]
    assign vmn_c = (volt_alert_threshold[7:0] != `FGAS_MIN_DIS) &&
        (cell_voltage_reading < volt_alert_threshold[7:0]); // [R14]

    always_comb begin
        next_status = 16'h0000;
        next_status[`FGAS_ST_BR] = keep_next(status[`FGAS_ST_BR],
            aux.remove_pulse, clr[`FGAS_ST_BR]); // [R07]
        next_status[`FGAS_ST_BI] = keep_next(status[`FGAS_ST_BI],
            aux.insert_pulse, clr[`FGAS_ST_BI]); // [R11]
        next_status[`FGAS_ST_POR] = keep_next(status[`FGAS_ST_POR],
            sw_por_req, clr[`FGAS_ST_POR]); // [R15]
        next_status[`FGAS_ST_BST] = !aux.present; // [R16]
        // non-sticky alerts track the condition directly [R17]
        next_status[`FGAS_ST_SMX] = alert_next(status[`FGAS_ST_SMX], smx_c,
            soc_sticky_select, clr[`FGAS_ST_SMX]); // [R12]
        next_status[`FGAS_ST_SMN] = alert_next(status[`FGAS_ST_SMN], smn_c,
            soc_sticky_select, clr[`FGAS_ST_SMN]); // [R12]
        next_status[`FGAS_ST_TMX] = alert_next(status[`FGAS_ST_TMX], tmx_c,
            temp_sticky_select, clr[`FGAS_ST_TMX]); // [R12]
        next_status[`FGAS_ST_TMN] = alert_next(status[`FGAS_ST_TMN], tmn_c,
            temp_sticky_select, clr[`FGAS_ST_TMN]); // [R12]
        next_status[`FGAS_ST_VMX] = alert_next(status[`FGAS_ST_VMX], vmx_c,
            volt_sticky_select, clr[`FGAS_ST_VMX]); // [R12]
        next_status[`FGAS_ST_VMN] = alert_next(status[`FGAS_ST_VMN], vmn_c,
            volt_sticky_select, clr[`FGAS_ST_VMN]); // [R12]
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            status <= `FGAS_STATUS_RST; // [R15]
        end else begin
            status <= next_status;
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            temp_limits <= `FGAS_TEMP_LIM_RST;
            smart_cfg <= `FGAS_CFG_RST;
        end else if (reg_wr) begin
            case (reg_addr)
                `FGAS_OFS_TEMP_LIM: begin
                    temp_limits <= reg_wdata; // [R01] [R02]
                end
                `FGAS_OFS_CFG: begin
                    smart_cfg <= reg_wdata & `FGAS_CFG_MASK;
                end
                default: begin
                    smart_cfg <= smart_cfg;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            reg_rdata <= 16'h0000;
            reg_ack <= 1'b0;
        end else begin
            reg_ack <= reg_rd || reg_wr;
            if (reg_rd) begin
                case (reg_addr)
                    `FGAS_OFS_STATUS: begin
                        reg_rdata <= status; // [R13]
                    end
                    `FGAS_OFS_TEMP_LIM: begin
                        reg_rdata <= temp_limits;
                    end
                    `FGAS_OFS_CFG: begin
                        reg_rdata <= smart_cfg;
                    end
                    default: begin
                        reg_rdata <= 16'h0000;
                    end
                endcase
            end
        end
    end

    // zones only matter to smart charging, so they idle while it is off
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            monitor_adjust_en <= 1'b1;
            smart_charge_function <= 1'b0;
            smart_full_function <= 1'b0;
            smart_soc <= 8'h00;
            warm_zone <= 1'b0;
            cool_zone <= 1'b0;
        end else begin
            monitor_adjust_en <= !smart_cfg[`FGAS_CFG_TMD]; // [R03]
            smart_charge_function <= smart_cfg[`FGAS_CFG_SCE]; // [R05]
            smart_full_function <= smart_cfg[`FGAS_CFG_SFE]; // [R06]
            smart_soc <= (smart_cfg[`FGAS_CFG_SRC] == fgas_soc_voltage) ?
                voltage_soc_estimate : mixed_soc_estimate; // [R04]
            warm_zone <= smart_cfg[`FGAS_CFG_SCE] &&
                (temp_limits[15:8] != `FGAS_WARM_DIS) &&
                gt_s(temperature_reading, temp_limits[15:8]); // [R01] [R19]
            cool_zone <= smart_cfg[`FGAS_CFG_SCE] &&
                (temp_limits[7:0] != `FGAS_COOL_DIS) &&
                gt_s(temp_limits[7:0], temperature_reading); // [R02] [R19]
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    sequence cfg_write_s(int b);
        reg_wr && (reg_addr == `FGAS_OFS_CFG) && reg_wdata[b];
    endsequence

    sequence cfg_settle_s;
        ##2 1'b1;
    endsequence

    removal_latch_a: assert property ( // [R07]
        aux.remove_pulse |=> status[`FGAS_ST_BR] [*2] or
            (status[`FGAS_ST_BR] ##1 $past(clr[`FGAS_ST_BR])))
        else $error("removal flag not latched");
    insert_latch_a: assert property ( // [R11]
        aux.insert_pulse |=> status[`FGAS_ST_BI])
        else $error("insertion flag not latched");
    clear_wins_a: assert property ( // [R18]
        st_wr && !reg_wdata[`FGAS_ST_BI] && !aux.insert_pulse
            |=> !status[`FGAS_ST_BI])
        else $error("zero write did not clear insertion flag");
    hold_one_a: assert property ( // [R18]
        status[`FGAS_ST_POR] && !(st_wr && !reg_wdata[`FGAS_ST_POR])
            |=> status[`FGAS_ST_POR])
        else $error("power-on flag dropped without a clear");
    por_set_a: assert property ( // [R15]
        sw_por_req |=> status[`FGAS_ST_POR])
        else $error("power-on flag not set by request");
    absent_level_a: assert property ( // [R16]
        aux.remove_pulse |=> status[`FGAS_ST_BST])
        else $error("battery absence not shown");
    temp_auto_a: assert property ( // [R17]
        !temp_sticky_select && !tmx_c |=> !status[`FGAS_ST_TMX])
        else $error("non-sticky temperature alert stayed set");
    volt_max_a: assert property ( // [R10]
        vmx_c |=> status[`FGAS_ST_VMX])
        else $error("voltage max alert missed");
    soc_min_a: assert property ( // [R14]
        smn_c |=> status[`FGAS_ST_SMN])
        else $error("soc min alert missed");
    warm_off_a: assert property ( // [R19]
        temp_limits[15:8] == `FGAS_WARM_DIS |=> !warm_zone)
        else $error("disabled warm threshold raised a zone");
    cool_off_a: assert property ( // [R02]
        temp_limits[7:0] == `FGAS_COOL_DIS |=> !cool_zone)
        else $error("disabled cool threshold raised a zone");
    monitor_stop_a: assert property ( // [R03]
        cfg_write_s(`FGAS_CFG_TMD) ##0 cfg_settle_s |-> !monitor_adjust_en)
        else $error("monitor adjustments not stopped");
    charge_en_a: assert property ( // [R05]
        cfg_write_s(`FGAS_CFG_SCE) ##0 cfg_settle_s |-> smart_charge_function)
        else $error("smart charge not enabled");
    full_en_a: assert property ( // [R06]
        cfg_write_s(`FGAS_CFG_SFE) ##0 cfg_settle_s |-> smart_full_function)
        else $error("smart full not enabled");
    soc_pick_a: assert property ( // [R04]
        smart_cfg[`FGAS_CFG_SRC] |=> smart_soc == $past(voltage_soc_estimate))
        else $error("voltage soc not selected");
    status_read_a: assert property ( // [R13]
        reg_rd && reg_addr == `FGAS_OFS_STATUS |=> reg_rdata == $past(status))
        else $error("status readback wrong");
    soc_max_a: assert property ( // [R08]
        smx_c |=> status[`FGAS_ST_SMX])
        else $error("soc max alert missed");
    temp_max_a: assert property ( // [R09]
        tmx_c |=> status[`FGAS_ST_TMX])
        else $error("temperature max alert missed");
    temp_min_a: assert property ( // [R14]
        tmn_c |=> status[`FGAS_ST_TMN])
        else $error("temperature min alert missed");
    volt_min_a: assert property ( // [R14]
        vmn_c |=> status[`FGAS_ST_VMN])
        else $error("voltage min alert missed");
    present_level_a: assert property ( // [R16]
        aux.insert_pulse |=> !status[`FGAS_ST_BST])
        else $error("battery presence not shown");
    temp_sticky_a: assert property ( // [R12]
        temp_sticky_select && status[`FGAS_ST_TMX] && !clr[`FGAS_ST_TMX]
            |=> status[`FGAS_ST_TMX])
        else $error("sticky temperature alert dropped");
    soc_auto_a: assert property ( // [R17]
        !soc_sticky_select && !smx_c |=> !status[`FGAS_ST_SMX])
        else $error("non-sticky soc alert stayed set");
    volt_auto_a: assert property ( // [R17]
        !volt_sticky_select && !vmn_c |=> !status[`FGAS_ST_VMN])
        else $error("non-sticky voltage alert stayed set");
    limits_write_a: assert property ( // [R01] [R02]
        reg_wr && reg_addr == `FGAS_OFS_TEMP_LIM
            |=> temp_limits == $past(reg_wdata))
        else $error("temperature limits not written");
    cfg_write_a: assert property ( // [R05] [R06]
        reg_wr && reg_addr == `FGAS_OFS_CFG
            |=> smart_cfg == ($past(reg_wdata) & `FGAS_CFG_MASK))
        else $error("smart charge configuration not written");
endmodule

// ### verification/test_fuel_gauge_alert_status.sv
`timescale 1ns/1ps
`include "fgas_regs.svh"
module test_fuel_gauge_alert_status
    import fgas_pkg::*;
;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic [7:0] reg_addr;
    logic reg_wr;
    logic reg_rd;
    fgas_word_t reg_wdata;
    fgas_word_t reg_rdata;
    logic reg_ack;
    fgas_byte_t mixed_soc_estimate, voltage_soc_estimate;
    fgas_byte_t temperature_reading, cell_voltage_reading;
    fgas_word_t soc_alert_threshold, temp_alert_threshold;
    fgas_word_t volt_alert_threshold;
    logic soc_sticky_select, temp_sticky_select, volt_sticky_select;
    logic [1:0] soc_alert_source_cfg;
    logic sw_por_req, aux_sense_input;
    logic monitor_adjust_en, smart_charge_function, smart_full_function;
    logic warm_zone, cool_zone;
    fgas_byte_t smart_soc;
    int fails = 0;
    int compares = 0;
    logic [15:0] lfsr = 16'he42d;
    fgas_word_t m_st, m_lim, m_cfg, rv;

    fgas_alert_status u_dut (
        .ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .reg_ack(reg_ack),
        .mixed_soc_estimate(mixed_soc_estimate),
        .voltage_soc_estimate(voltage_soc_estimate),
        .temperature_reading(temperature_reading),
        .cell_voltage_reading(cell_voltage_reading),
        .soc_alert_threshold(soc_alert_threshold),
        .temp_alert_threshold(temp_alert_threshold),
        .volt_alert_threshold(volt_alert_threshold),
        .soc_sticky_select(soc_sticky_select),
        .temp_sticky_select(temp_sticky_select),
        .volt_sticky_select(volt_sticky_select),
        .soc_alert_source_cfg(soc_alert_source_cfg),
        .sw_por_req(sw_por_req), .aux_sense_input(aux_sense_input),
        .monitor_adjust_en(monitor_adjust_en),
        .smart_charge_function(smart_charge_function),
        .smart_full_function(smart_full_function),
        .smart_soc(smart_soc), .warm_zone(warm_zone), .cool_zone(cool_zone)
    );

    always #20 ref_clk = ~ref_clk;

    initial begin
        #(40 * 40000);
        fails++;
        finish_test();
    end

    function automatic fgas_word_t rnd();
        lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
        return lfsr;
    endfunction

    // expected raw alert conditions from the live readings
    function automatic fgas_word_t alerts();
        fgas_word_t a;
        fgas_byte_t s;
        s = (soc_alert_source_cfg == 2'd1) ? voltage_soc_estimate
                                           : mixed_soc_estimate;
        a = 16'h0;
        a[14] = s > soc_alert_threshold[15:8];
        a[10] = s < soc_alert_threshold[7:0];
        a[13] = $signed(temperature_reading) >
                $signed(temp_alert_threshold[15:8]);
        a[9] = $signed(temperature_reading) <
               $signed(temp_alert_threshold[7:0]);
        a[12] = cell_voltage_reading > volt_alert_threshold[15:8];
        a[8] = cell_voltage_reading < volt_alert_threshold[7:0];
        return a;
    endfunction

    task automatic finish_test();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk(input string n, input fgas_word_t e,
                       input fgas_word_t g);
        compares++;
        if (g !== e) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic chk1(input string n, input logic e, input logic g);
        chk(n, {15'h0, e}, {15'h0, g});
    endtask

    // one strobe cycle, answer sampled in the acknowledge cycle
    task automatic reg_rw(input logic w, input logic [7:0] a,
                          input fgas_word_t d, output fgas_word_t q);
        @(posedge ref_clk);
        #1;
        reg_wr = w;
        reg_rd = ~w;
        reg_addr = a;
        reg_wdata = d;
        @(posedge ref_clk);
        #1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
        chk1("ack", 1'b1, reg_ack);
        q = reg_rdata;
    endtask

    task automatic wr(input logic [7:0] a, input fgas_word_t d);
        fgas_word_t q;
        reg_rw(1'b1, a, d, q);
        case (a)
            `FGAS_OFS_STATUS: m_st = m_st & (d | ~16'hff02);
            `FGAS_OFS_TEMP_LIM: m_lim = d;
            `FGAS_OFS_CFG: m_cfg = d & 16'h0033;
            default: ;
        endcase
    endtask

    task automatic rd(input logic [7:0] a, input fgas_word_t e,
                      input string n);
        fgas_word_t q;
        reg_rw(1'b0, a, 16'h0, q);
        chk(n, e, q);
    endtask

    // sticky bits accumulate, the others follow the condition
    task automatic settle();
        fgas_word_t a;
        fgas_word_t sm;
        repeat (3) @(posedge ref_clk);
        a = alerts();
        sm = {1'b0, soc_sticky_select, temp_sticky_select, volt_sticky_select,
              1'b0, soc_sticky_select, temp_sticky_select, volt_sticky_select,
              8'h0};
        m_st = (m_st & ~16'h7700) | (m_st & sm) | a;
        rd(`FGAS_OFS_STATUS, m_st, "status");
    endtask

    task automatic check_outs();
        fgas_byte_t w;
        fgas_byte_t c;
        fgas_byte_t t;
        w = m_lim[15:8];
        c = m_lim[7:0];
        @(posedge ref_clk);
        #1;
        t = temperature_reading;
        chk1("adjust", ~m_cfg[5], monitor_adjust_en);
        chk1("charge", m_cfg[1], smart_charge_function);
        chk1("full", m_cfg[0], smart_full_function);
        chk("soc", {8'h0, m_cfg[4] ? voltage_soc_estimate
                  : mixed_soc_estimate}, {8'h0, smart_soc});
        chk1("warm", m_cfg[1] && w != 8'h7f
             && $signed(t) > $signed(w), warm_zone);
        chk1("cool", m_cfg[1] && c != 8'h80
             && $signed(t) < $signed(c), cool_zone);
    endtask

    task automatic quiet(input fgas_byte_t v, input fgas_byte_t t);
        mixed_soc_estimate = v;
        voltage_soc_estimate = v;
        cell_voltage_reading = v;
        temperature_reading = t;
        soc_alert_threshold = 16'hff00;
        temp_alert_threshold = 16'h7f80;
        volt_alert_threshold = 16'hff00;
    endtask

    initial begin
        reg_addr = 8'h0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = 16'h0;
        quiet(8'h40, 8'h19);
        {soc_sticky_select, temp_sticky_select, volt_sticky_select} = 3'h0;
        soc_alert_source_cfg = 2'h0;
        sw_por_req = 1'b0;
        aux_sense_input = 1'b0;
        m_st = 16'h0002;
        m_lim = 16'h7f80;
        m_cfg = 16'h0;
        repeat (3) @(posedge ref_clk);
        #1;
        reset = 1'b0;
        rd(`FGAS_OFS_STATUS, m_st, "status");
        rd(`FGAS_OFS_TEMP_LIM, m_lim, "limits");
        rd(`FGAS_OFS_CFG, m_cfg, "cfg");
        wr(8'h55, 16'hffff);
        rd(8'h55, 16'h0, "unmapped");
        wr(`FGAS_OFS_STATUS, 16'h0);
        for (int i = 0; i < 48; i++) begin
            {mixed_soc_estimate, voltage_soc_estimate} = rnd();
            {temperature_reading, cell_voltage_reading} = rnd();
            soc_alert_threshold = rnd();
            temp_alert_threshold = (i % 8 == 0) ? 16'h7f80 : rnd();
            volt_alert_threshold = rnd();
            rv = rnd();
            {soc_sticky_select, temp_sticky_select, volt_sticky_select,
             soc_alert_source_cfg} = rv[4:0];
            wr(`FGAS_OFS_CFG, rnd());
            wr(`FGAS_OFS_TEMP_LIM, (i % 8 == 1) ? 16'h7f80 : rnd());
            settle();
            rd(`FGAS_OFS_TEMP_LIM, m_lim, "limits");
            rd(`FGAS_OFS_CFG, m_cfg, "cfg");
            check_outs();
            if (i % 3 == 0) begin
                wr(`FGAS_OFS_STATUS, rnd());
                settle();
            end
        end
        // disabled codes at extreme readings never alert
        quiet(8'h00, 8'h80);
        settle();
        quiet(8'hff, 8'h7f);
        wr(`FGAS_OFS_TEMP_LIM, 16'h7f80);
        wr(`FGAS_OFS_CFG, 16'h0002);
        settle();
        check_outs();
        // detector needs a few cycles to call the pin stable
        aux_sense_input = 1'b1;
        repeat (10) @(posedge ref_clk);
        m_st = m_st | 16'h8008;
        rd(`FGAS_OFS_STATUS, m_st, "status");
        wr(`FGAS_OFS_STATUS, 16'h7fff);
        rd(`FGAS_OFS_STATUS, m_st, "status");
        aux_sense_input = 1'b0;
        repeat (10) @(posedge ref_clk);
        m_st = (m_st | 16'h0800) & ~16'h0008;
        rd(`FGAS_OFS_STATUS, m_st, "status");
        wr(`FGAS_OFS_STATUS, 16'hf7ff);
        rd(`FGAS_OFS_STATUS, m_st, "status");
        @(posedge ref_clk);
        #1;
        sw_por_req = 1'b1;
        @(posedge ref_clk);
        #1;
        sw_por_req = 1'b0;
        repeat (2) @(posedge ref_clk);
        m_st = m_st | 16'h0002;
        rd(`FGAS_OFS_STATUS, m_st, "status");
        @(posedge ref_clk);
        #1;
        reset = 1'b1;
        repeat (2) @(posedge ref_clk);
        #1;
        reset = 1'b0;
        m_st = 16'h0002;
        m_lim = 16'h7f80;
        m_cfg = 16'h0;
        rd(`FGAS_OFS_STATUS, m_st, "status");
        rd(`FGAS_OFS_CFG, m_cfg, "cfg");
        check_outs();
        finish_test();
    end
endmodule
